// [pdsc_top.sv]
/*
  Output conditioning of two PID controllers: feedforward gain, dead band
  freeze with release delay, and sleep mode with wake conditions.
  Assumes all inputs are synchronous to sys_clk; values are signed 16 bit.
*/
`include "pdsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pdsc_top
  import pdsc_pkg::*;
#(
  parameter int TICK_CYCLES = `PDSC_TICK_NS / `PDSC_CLK_NS
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Drive quantities shared by both controllers
  input  wire pdsc_val_t         out_frequency,
  input  wire pdsc_val_t         motor_speed,
  input  wire pdsc_val_t         motor_current,
  // Controller 1 process signals
  input  wire pdsc_val_t         ctl1_ff_in,
  input  wire pdsc_val_t         ctl1_error,
  input  wire pdsc_val_t         ctl1_pid_raw,
  input  wire pdsc_val_t         ctl1_feedback,
  input  wire pdsc_val_t         ctl1_setpoint,
  input  wire logic              ctl1_sp2_active,
  // Controller 1 configuration
  input  wire pdsc_val_t         ctl1_feedforward_gain,
  input  wire logic [15:0]       ctl1_dead_band_width,
  input  wire logic [15:0]       ctl1_dead_band_delay,
  input  wire logic              ctl1_sp1_sleep_enable,
  input  wire logic [1:0]        ctl1_sp1_sleep_ref_select,
  input  wire pdsc_val_t         ctl1_sp1_sleep_level,
  input  wire logic [18:0]       ctl1_sp1_sleep_delay,
  input  wire pdsc_val_t         ctl1_sp1_wake_level,
  input  wire logic              ctl1_sp2_sleep_enable,
  input  wire logic [1:0]        ctl1_sp2_sleep_ref_select,
  input  wire pdsc_val_t         ctl1_sp2_sleep_level,
  input  wire logic [18:0]       ctl1_sp2_sleep_delay,
  input  wire pdsc_val_t         ctl1_sp2_wake_level,
  input  wire logic [1:0]        ctl1_wake_action,
  // Controller 2 process signals
  input  wire pdsc_val_t         ctl2_ff_in,
  input  wire pdsc_val_t         ctl2_error,
  input  wire pdsc_val_t         ctl2_pid_raw,
  input  wire pdsc_val_t         ctl2_feedback,
  input  wire pdsc_val_t         ctl2_setpoint,
  input  wire logic              ctl2_sp2_active,
  // Controller 2 configuration
  input  wire pdsc_val_t         ctl2_feedforward_gain,
  input  wire logic [15:0]       ctl2_dead_band_width,
  input  wire logic [15:0]       ctl2_dead_band_delay,
  input  wire logic              ctl2_sp1_sleep_enable,
  input  wire logic [1:0]        ctl2_sp1_sleep_ref_select,
  input  wire pdsc_val_t         ctl2_sp1_sleep_level,
  input  wire logic [18:0]       ctl2_sp1_sleep_delay,
  input  wire pdsc_val_t         ctl2_sp1_wake_level,
  input  wire logic              ctl2_sp2_sleep_enable,
  input  wire logic [1:0]        ctl2_sp2_sleep_ref_select,
  input  wire pdsc_val_t         ctl2_sp2_sleep_level,
  input  wire logic [18:0]       ctl2_sp2_sleep_delay,
  input  wire pdsc_val_t         ctl2_sp2_wake_level,
  input  wire logic [1:0]        ctl2_wake_action,
  // Controller 1 results
  output var pdsc_val_t          ctl1_output_monitor,
  output var pdsc_val_t          ctl1_ff_scaled,
  output var logic               ctl1_frozen,
  output var logic               ctl1_asleep,
  // Controller 2 results
  output var pdsc_val_t          ctl2_output_monitor,
  output var pdsc_val_t          ctl2_ff_scaled,
  output var logic               ctl2_frozen,
  output var logic               ctl2_asleep
);

  // ****************************************
  // Limits and helpers
  // ****************************************
  localparam logic [15:0] DB_MAX = 16'(`PDSC_DB_DELAY_MAX_S * `PDSC_TICKS_PER_S);
  localparam logic [18:0] SL_MAX = 19'(`PDSC_SLEEP_DELAY_MAX_S * `PDSC_TICKS_PER_S);

  // Saturates instead of wrapping, a wrapped gain would flip the drive direction
  function automatic pdsc_val_t scale(pdsc_val_t a, pdsc_val_t b);
    logic signed [31:0] p;
    p = (32'(a) * 32'(b)) / `PDSC_PCT_DIV;
    if (p > 32'sh7fff) begin
      scale = 16'sh7fff;
    end else if (p < -32'sh8000) begin
      scale = 16'sh8000;
    end else begin
      scale = p[15:0];
    end
  endfunction : scale

  function automatic pdsc_val_t gain_lim(pdsc_val_t g);
    if (g > `PDSC_GAIN_MAX) begin
      gain_lim = `PDSC_GAIN_MAX;
    end else if (g < `PDSC_GAIN_MIN) begin
      gain_lim = `PDSC_GAIN_MIN;
    end else begin
      gain_lim = g;
    end
  endfunction : gain_lim

  function automatic pdsc_val_t ref_val(logic [1:0] sel, pdsc_val_t fb);
    case (pdsc_ref_e'(sel))
      PDSC_REF_FREQ:  ref_val = out_frequency;
      PDSC_REF_SPEED: ref_val = motor_speed;
      PDSC_REF_CURR:  ref_val = motor_current;
      PDSC_REF_FB:    ref_val = fb;
      default:        ref_val = out_frequency;
    endcase
  endfunction : ref_val

  // Set point relative levels are in 0.1 % of the present set point
  function automatic logic wake_met(logic [1:0] act, pdsc_val_t fb, pdsc_val_t sp,
                                    pdsc_val_t wl);
    case (pdsc_wake_e'(act))
      PDSC_WAKE_BELOW:    wake_met = fb < wl;
      PDSC_WAKE_ABOVE:    wake_met = fb > wl;
      PDSC_WAKE_BELOW_SP: wake_met = fb < scale(sp, wl);
      PDSC_WAKE_ABOVE_SP: wake_met = fb > scale(sp, wl);
      default:            wake_met = 1'b0;
    endcase
  endfunction : wake_met

  // ****************************************
  // Per controller selection
  // ****************************************
  pdsc_val_t [1:0]   ff_a;
  pdsc_val_t [1:0]   gain_a;
  pdsc_val_t [1:0]   err_a;
  pdsc_val_t [1:0]   pid_a;
  logic [1:0][15:0]  dbw_a;
  logic [1:0][15:0]  db_dly;
  logic [1:0]        in_band;
  logic [1:0]        sel_en;
  logic [1:0][18:0]  sl_dly;
  logic [1:0]        below;
  logic [1:0]        wake;
  pdsc_val_t [1:0]   ff_exp;

  assign ff_a   = {ctl2_ff_in, ctl1_ff_in};
  assign gain_a = {ctl2_feedforward_gain, ctl1_feedforward_gain};
  assign err_a  = {ctl2_error, ctl1_error};
  assign pid_a  = {ctl2_pid_raw, ctl1_pid_raw};
  assign dbw_a  = {ctl2_dead_band_width, ctl1_dead_band_width};

  // Strict less-than: a zero width can never freeze
  for (genvar g = 0; g < 2; g++) begin : g_band
    logic [16:0] mag;
    assign mag = err_a[g][15] ? 17'(-{err_a[g][15], err_a[g]}) : {1'b0, err_a[g]};
    assign in_band[g] = mag < {1'b0, dbw_a[g]};
    assign ff_exp[g]  = scale(ff_a[g], gain_lim(gain_a[g]));
  end

  logic [1:0][18:0] dly_raw;
  assign dly_raw[0] = ctl1_sp2_active ? ctl1_sp2_sleep_delay : ctl1_sp1_sleep_delay;
  assign dly_raw[1] = ctl2_sp2_active ? ctl2_sp2_sleep_delay : ctl2_sp1_sleep_delay;
  assign sel_en[0]  = ctl1_sp2_active ? ctl1_sp2_sleep_enable : ctl1_sp1_sleep_enable;
  assign sel_en[1]  = ctl2_sp2_active ? ctl2_sp2_sleep_enable : ctl2_sp1_sleep_enable;
  assign below[0] = ctl1_sp2_active
    ? ref_val(ctl1_sp2_sleep_ref_select, ctl1_feedback) < ctl1_sp2_sleep_level
    : ref_val(ctl1_sp1_sleep_ref_select, ctl1_feedback) < ctl1_sp1_sleep_level;
  assign below[1] = ctl2_sp2_active
    ? ref_val(ctl2_sp2_sleep_ref_select, ctl2_feedback) < ctl2_sp2_sleep_level
    : ref_val(ctl2_sp1_sleep_ref_select, ctl2_feedback) < ctl2_sp1_sleep_level;
  assign wake[0] = wake_met(ctl1_wake_action, ctl1_feedback, ctl1_setpoint,
                            ctl1_sp2_active ? ctl1_sp2_wake_level : ctl1_sp1_wake_level);
  assign wake[1] = wake_met(ctl2_wake_action, ctl2_feedback, ctl2_setpoint,
                            ctl2_sp2_active ? ctl2_sp2_wake_level : ctl2_sp1_wake_level);
  // Out of range settings are clamped to the longest delay
  assign db_dly[0] = (ctl1_dead_band_delay > DB_MAX) ? DB_MAX : ctl1_dead_band_delay;
  assign db_dly[1] = (ctl2_dead_band_delay > DB_MAX) ? DB_MAX : ctl2_dead_band_delay;
  assign sl_dly[0] = (dly_raw[0] > SL_MAX) ? SL_MAX : dly_raw[0];
  assign sl_dly[1] = (dly_raw[1] > SL_MAX) ? SL_MAX : dly_raw[1];

  // ****************************************
  // Time base
  // ****************************************
  pdsc_tick_if tk ();

  pdsc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tk      (tk.src)
  );

  // ****************************************
  // State
  // ****************************************
  pdsc_state_s st_q;
  pdsc_state_s st_d;

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 2; i++) begin
      st_d.c[i].ff = ff_exp[i];
      case (st_q.c[i].db)
        PDSC_DB_RUN: if (in_band[i]) begin
          st_d.c[i].db   = PDSC_DB_HOLD;
          st_d.c[i].hold = pid_a[i];
        end
        PDSC_DB_HOLD: if (!in_band[i]) begin
          st_d.c[i].db     = PDSC_DB_WAIT;
          st_d.c[i].db_cnt = '0;
        end
        PDSC_DB_WAIT: if (in_band[i]) begin
          st_d.c[i].db     = PDSC_DB_HOLD;
          st_d.c[i].db_cnt = '0;
        end else if (st_q.c[i].db_cnt >= db_dly[i]) begin
          st_d.c[i].db = PDSC_DB_RUN;
        end else if (tk.tick) begin
          st_d.c[i].db_cnt = st_q.c[i].db_cnt + 16'h0001;
        end
        default: st_d.c[i].db = PDSC_DB_RUN;
      endcase
      st_d.c[i].frozen = st_d.c[i].db != PDSC_DB_RUN;
      if (st_q.c[i].asleep) begin
        st_d.c[i].sl_cnt = '0;
        if (!sel_en[i] || wake[i]) begin
          st_d.c[i].asleep = 1'b0;
        end
      end else if (!sel_en[i] || !below[i]) begin
        st_d.c[i].sl_cnt = '0;
      end else if (tk.tick) begin
        if (st_q.c[i].sl_cnt >= sl_dly[i]) begin
          st_d.c[i].asleep = 1'b1;
        end else begin
          st_d.c[i].sl_cnt = st_q.c[i].sl_cnt + 19'h00001;
        end
      end
      if (st_d.c[i].asleep) begin
        st_d.c[i].out = '0;
      end else if (st_d.c[i].frozen) begin
        st_d.c[i].out = st_d.c[i].hold;
      end else begin
        st_d.c[i].out = pid_a[i];
      end
    end
    if (rst) begin
      st_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign ctl1_output_monitor = st_q.c[0].out;
  assign ctl1_ff_scaled      = st_q.c[0].ff;
  assign ctl1_frozen         = st_q.c[0].frozen;
  assign ctl1_asleep         = st_q.c[0].asleep;
  assign ctl2_output_monitor = st_q.c[1].out;
  assign ctl2_ff_scaled      = st_q.c[1].ff;
  assign ctl2_frozen         = st_q.c[1].frozen;
  assign ctl2_asleep         = st_q.c[1].asleep;

  // ****************************************
  // Assertions, controller 1
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_ff_gain; !rst |=> ctl1_ff_scaled == $past(ff_exp[0]); endproperty
  a_ff_gain: assert property (p_ff_gain) else $error("ff gain wrong");
  property p_hold; ctl1_frozen && !ctl1_asleep |-> ctl1_output_monitor == st_q.c[0].hold;
  endproperty
  a_hold: assert property (p_hold) else $error("frozen output moved");
  property p_no_band; st_q.c[0].db == PDSC_DB_RUN && dbw_a[0] == 16'h0000 |=> !ctl1_frozen;
  endproperty
  a_no_band: assert property (p_no_band) else $error("zero band froze");
  property p_sleep_out; ctl1_asleep |-> ctl1_output_monitor == 16'sh0000; endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("sleep not zero");
  property p_reset; disable iff (1'b0) rst |=> !ctl1_asleep && !ctl2_asleep; endproperty
  a_reset: assert property (p_reset) else $error("asleep after reset");
  property p_en_off; !sel_en[0] |=> !ctl1_asleep; endproperty
  a_en_off: assert property (p_en_off) else $error("asleep while disabled");
  property p_enter; $rose(ctl1_asleep) |-> $past(below[0]) && $past(sel_en[0]); endproperty
  a_enter: assert property (p_enter) else $error("sleep without cause");
  property p_wake; ctl1_asleep && wake[0] |=> !ctl1_asleep; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_restart; !ctl1_asleep && !below[0] |=> st_q.c[0].sl_cnt == 19'h00000;
  endproperty
  a_restart: assert property (p_restart) else $error("sleep timer kept");
  property p_db_wait; st_q.c[0].db == PDSC_DB_WAIT && in_band[0]
    |=> st_q.c[0].db == PDSC_DB_HOLD && st_q.c[0].db_cnt == 16'h0000 && $stable(st_q.c[0].hold);
  endproperty
  a_db_wait: assert property (p_db_wait) else $error("band re-entry");

endmodule : pdsc_top
`default_nettype wire

// [pdsc_defines.svh]
/*
  Constants of the PID dead band and sleep output conditioning block:
  timing, scaling and the reset/default values of the configuration ports.
  Assumes the including file uses a 25 MHz system clock.
*/
// Summary of operation
// - Feedforward is multiplied by a gain of -1000 % to +1000 %, default 100 %.
// - While absolute error is inside the dead band, the output is held unchanged.
// - Dead band width is in process units and defaults to zero, so no freezing.
// - After leaving the band, wait the dead band delay (0 to 320 s) before control.
// - Asleep forces the output to zero; waking restores normal output.
// - After reset sleep is inactive for both set point channels.
// - Separate sleep settings per set point; the active set point picks the set.
// - Sleep enable zero keeps the controller active; one allows sleep and wake.
// - Sleep reference code 0 frequency, 1 speed, 2 current, 3 feedback.
// - Sleep is entered after the reference stays below the level longer than the delay.
// - Once asleep, stay asleep until the wake condition holds or sleep is disabled, then run normally.
// - One wake action setting serves both set point channels of a controller.
// - Wake action 0 wakes when feedback falls below the fixed wake level.
// - Wake action 1 wakes when feedback rises above the fixed wake level.
// - Wake actions 2 and 3 use a set point percentage; 2 below, 3 above.
// - Each sleep delay spans 0 to 3000 s, default zero.
// - Wake action defaults to code 0; each sleep enable defaults to disabled.
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define PDSC_CLK_NS          40
`define PDSC_TICK_NS         10000000
`define PDSC_TICKS_PER_S     (1000000000 / `PDSC_TICK_NS)
`define PDSC_DB_DELAY_MAX_S  320
`define PDSC_SLEEP_DELAY_MAX_S 3000

// ****************************************
// Scaling, gain in 0.1 % steps
// ****************************************
`define PDSC_PCT_DIV         32'sh3e8
`define PDSC_GAIN_MAX        16'sh2710
`define PDSC_GAIN_MIN        (-16'sh2710)

// ****************************************
// Defaults of configuration ports
// ****************************************
`define PDSC_FF_GAIN_DFLT    16'sh03e8
`define PDSC_DB_WIDTH_DFLT   16'h0000
`define PDSC_DB_DELAY_DFLT   16'h0000
`define PDSC_SLEEP_EN_DFLT   1'h0
`define PDSC_REF_SEL_DFLT    2'h0
`define PDSC_SLEEP_LVL_DFLT  16'sh0000
`define PDSC_SLEEP_DLY_DFLT  19'h00000
`define PDSC_WAKE_LVL_DFLT   16'sh0000
`define PDSC_WAKE_ACT_DFLT   2'h0

`endif

// [pdsc_pkg.sv]
/*
  Types of the PID dead band and sleep block: modes, codes and state.
  Assumes the defines header is available for the constants.
*/
`default_nettype none
package pdsc_pkg;

  // ****************************************
  // Modes and codes
  // ****************************************
  typedef enum logic [1:0] {
    PDSC_DB_RUN  = 2'h0,
    PDSC_DB_HOLD = 2'h1,
    PDSC_DB_WAIT = 2'h3
  } pdsc_db_e;

  typedef enum logic [1:0] {
    PDSC_REF_FREQ  = 2'h0,
    PDSC_REF_SPEED = 2'h1,
    PDSC_REF_CURR  = 2'h2,
    PDSC_REF_FB    = 2'h3
  } pdsc_ref_e;

  typedef enum logic [1:0] {
    PDSC_WAKE_BELOW    = 2'h0,
    PDSC_WAKE_ABOVE    = 2'h1,
    PDSC_WAKE_BELOW_SP = 2'h2,
    PDSC_WAKE_ABOVE_SP = 2'h3
  } pdsc_wake_e;

  typedef logic signed [15:0] pdsc_val_t;

  // ****************************************
  // State of one controller and of the block
  // ****************************************
  typedef struct packed {
    pdsc_db_e    db;
    logic [15:0] db_cnt;
    pdsc_val_t   hold;
    logic        frozen;
    logic        asleep;
    logic [18:0] sl_cnt;
    pdsc_val_t   ff;
    pdsc_val_t   out;
  } pdsc_ctl_s;

  typedef struct packed {
    pdsc_ctl_s [1:0] c;
  } pdsc_state_s;

endpackage : pdsc_pkg
`default_nettype wire

// [pdsc_tick_if.sv]
/*
  Time base carrier between the tick generator and the controller logic.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pdsc_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : pdsc_tick_if
`default_nettype wire

// [pdsc_tick.sv]
/*
  Tick generator: one-cycle pulse every TICK_CYCLES system clocks.
  Assumes a synchronous active-high reset.
*/
`include "pdsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pdsc_tick
  import pdsc_pkg::*;
#(
  parameter int TICK_CYCLES = `PDSC_TICK_NS / `PDSC_CLK_NS
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rst,
  // Time base out
  pdsc_tick_if.src   tk
);
  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } pdsc_tick_s;

  pdsc_tick_s st_q;
  pdsc_tick_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == CW'(TICK_CYCLES - 1)) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
    if (rst) begin
      st_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign tk.tick = st_q.tick;

endmodule : pdsc_tick
`default_nettype wire

// [pdsc_drive_model.sv]
/*
  Drive model for the sleep references: output frequency moves toward a
  target by at most one step per clock; speed and current follow it.
  Assumes sys_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pdsc_drive_model
  import pdsc_pkg::*;
(
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // Command
  input  wire pdsc_val_t target,
  input  wire pdsc_val_t step,
  // Drive quantities
  output var  pdsc_val_t out_frequency,
  output var  pdsc_val_t motor_speed,
  output var  pdsc_val_t motor_current
);
  // ****************************************
  // Ramp
  // ****************************************
  logic signed [16:0] diff;
  assign diff = 17'(target) - 17'(out_frequency);
  // Small step mimics a slow motor; a large one answers at once
  always_ff @(posedge sys_clk) begin
    if (rst)
      out_frequency <= 16'sh0000;
    else if (diff > step)
      out_frequency <= out_frequency + step;
    else if (diff < -step)
      out_frequency <= out_frequency - step;
    else
      out_frequency <= target;
  end
  assign motor_speed   = out_frequency <<< 1;
  // Current stays at or above the magnetising part while the frequency is not negative
  assign motor_current = (out_frequency >>> 2) + 16'sh0032;
endmodule : pdsc_drive_model
`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench: both controllers get the same stimulus, the drive
  model supplies the sleep references.
  Assumes a tick of 4 clocks so that every delay stays short.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import pdsc_pkg::*;
  // ****************************************
  // Signals and tables
  // ****************************************
  typedef struct {pdsc_val_t g; pdsc_val_t f; pdsc_val_t e;} pdsc_tb_ff_s;
  typedef struct {logic [1:0] sel; pdsc_val_t lvl; logic s;} pdsc_tb_sel_s;
  typedef struct {logic [1:0] a; pdsc_val_t sp; pdsc_val_t h; pdsc_val_t t; logic s;} pdsc_tb_wk_s;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  int          mismatches = 0;
  int          tests_run = 0;
  pdsc_val_t   tgt, stp, out_frequency, motor_speed, motor_current;
  pdsc_val_t   ctl1_ff_in, ctl1_error, ctl1_pid_raw, ctl1_feedback, ctl1_setpoint;
  pdsc_val_t   ctl1_feedforward_gain, ctl1_sp1_sleep_level, ctl1_sp1_wake_level;
  pdsc_val_t   ctl1_sp2_sleep_level, ctl1_sp2_wake_level;
  pdsc_val_t   ctl1_output_monitor, ctl1_ff_scaled, ctl2_output_monitor, ctl2_ff_scaled;
  logic        ctl1_sp2_active, ctl1_sp1_sleep_enable, ctl1_sp2_sleep_enable;
  logic        ctl1_frozen, ctl1_asleep, ctl2_frozen, ctl2_asleep;
  logic [15:0] ctl1_dead_band_width, ctl1_dead_band_delay;
  logic [1:0]  ctl1_sp1_sleep_ref_select, ctl1_sp2_sleep_ref_select, ctl1_wake_action;
  logic [18:0] ctl1_sp1_sleep_delay, ctl1_sp2_sleep_delay;
  pdsc_tb_ff_s  ffr [8] = '{'{16'sh03e8, 16'sh01f4, 16'sh01f4}, '{-16'sh2710, 16'sh0064, -16'sh03e8},
    '{16'sh2710, 16'sh1388, 16'sh7fff}, '{16'sh4e20, 16'sh000a, 16'sh0064},
    '{16'sh014d, -16'sh0007, -16'sh0002}, '{-16'sh2710, 16'sh1388, 16'sh8000},
    '{16'sh0000, 16'sh1000, 16'sh0000}, '{-16'sh4e20, 16'sh0002, -16'sh0014}};
  pdsc_tb_sel_s sr [8] = '{'{2'h0, 16'sh01f4, 1'b1}, '{2'h1, 16'sh01f4, 1'b0},
    '{2'h2, 16'sh01f4, 1'b1}, '{2'h3, 16'sh01f4, 1'b0}, '{2'h1, 16'sh0384, 1'b1},
    '{2'h2, 16'sh0064, 1'b0}, '{2'h3, 16'sh044c, 1'b1}, '{2'h0, 16'sh012c, 1'b0}};
  pdsc_tb_wk_s  wr [8] = '{'{2'h0, 16'sh0000, 16'sh0258, 16'sh0190, 1'b0},
    '{2'h0, 16'sh0000, 16'sh0258, 16'sh0226, 1'b1}, '{2'h1, 16'sh0000, 16'sh0190, 16'sh0258, 1'b0},
    '{2'h1, 16'sh0000, 16'sh0190, 16'sh01c2, 1'b1}, '{2'h2, 16'sh03e8, 16'sh0258, 16'sh0190, 1'b0},
    '{2'h2, 16'sh0258, 16'sh0258, 16'sh0190, 1'b1}, '{2'h3, 16'sh03e8, 16'sh0190, 16'sh0258, 1'b0},
    '{2'h3, 16'sh07d0, 16'sh0190, 16'sh0258, 1'b1}};

  always #20 sys_clk = ~sys_clk;

  pdsc_drive_model u_pdsc_drive_model (.sys_clk, .rst, .target(tgt), .step(stp),
    .out_frequency, .motor_speed, .motor_current);
  // Controller 2 mirrors controller 1, so both must answer alike
  pdsc_top #(.TICK_CYCLES(4)) u_pdsc_top (.sys_clk, .rst, .out_frequency, .motor_speed,
    .motor_current, .ctl1_ff_in, .ctl1_error, .ctl1_pid_raw, .ctl1_feedback, .ctl1_setpoint,
    .ctl1_sp2_active, .ctl1_feedforward_gain, .ctl1_dead_band_width, .ctl1_dead_band_delay,
    .ctl1_sp1_sleep_enable, .ctl1_sp1_sleep_ref_select, .ctl1_sp1_sleep_level,
    .ctl1_sp1_sleep_delay, .ctl1_sp1_wake_level, .ctl1_sp2_sleep_enable,
    .ctl1_sp2_sleep_ref_select, .ctl1_sp2_sleep_level, .ctl1_sp2_sleep_delay,
    .ctl1_sp2_wake_level, .ctl1_wake_action, .ctl2_ff_in(ctl1_ff_in), .ctl2_error(ctl1_error),
    .ctl2_pid_raw(ctl1_pid_raw), .ctl2_feedback(ctl1_feedback), .ctl2_setpoint(ctl1_setpoint),
    .ctl2_sp2_active(ctl1_sp2_active), .ctl2_feedforward_gain(ctl1_feedforward_gain),
    .ctl2_dead_band_width(ctl1_dead_band_width), .ctl2_dead_band_delay(ctl1_dead_band_delay),
    .ctl2_sp1_sleep_enable(ctl1_sp1_sleep_enable),
    .ctl2_sp1_sleep_ref_select(ctl1_sp1_sleep_ref_select),
    .ctl2_sp1_sleep_level(ctl1_sp1_sleep_level), .ctl2_sp1_sleep_delay(ctl1_sp1_sleep_delay),
    .ctl2_sp1_wake_level(ctl1_sp1_wake_level), .ctl2_sp2_sleep_enable(ctl1_sp2_sleep_enable),
    .ctl2_sp2_sleep_ref_select(ctl1_sp2_sleep_ref_select),
    .ctl2_sp2_sleep_level(ctl1_sp2_sleep_level), .ctl2_sp2_sleep_delay(ctl1_sp2_sleep_delay),
    .ctl2_sp2_wake_level(ctl1_sp2_wake_level), .ctl2_wake_action(ctl1_wake_action),
    .ctl1_output_monitor, .ctl1_ff_scaled, .ctl1_frozen, .ctl1_asleep,
    .ctl2_output_monitor, .ctl2_ff_scaled, .ctl2_frozen, .ctl2_asleep);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : go
  // Looks at the falling edge, where the registered outputs have settled
  task automatic st(input pdsc_val_t o, input logic f, input logic s);
    @(negedge sys_clk);
    `CHK(ctl1_output_monitor, o)
    `CHK(ctl2_output_monitor, o)
    `CHK(ctl1_frozen, f)
    `CHK(ctl2_frozen, f)
    `CHK(ctl1_asleep, s)
    `CHK(ctl2_asleep, s)
  endtask : st
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #(3000 * 40);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    int i;
    tgt = 16'sh0000; stp = 16'sh7fff; ctl1_ff_in = 16'sh0111; ctl1_error = 16'sh0000;
    ctl1_pid_raw = 16'sh0123; ctl1_feedback = 16'sh03e8; ctl1_setpoint = 16'sh0000;
    ctl1_sp2_active = 1'b0; ctl1_feedforward_gain = 16'sh03e8; ctl1_dead_band_width = 16'h0000;
    ctl1_dead_band_delay = 16'h0000; ctl1_sp1_sleep_enable = 1'b0; ctl1_sp2_sleep_enable = 1'b0;
    ctl1_sp1_sleep_ref_select = 2'h0; ctl1_sp2_sleep_ref_select = 2'h0;
    ctl1_sp1_sleep_level = 16'sh0000; ctl1_sp2_sleep_level = 16'sh0000;
    ctl1_sp1_sleep_delay = 19'h00000; ctl1_sp2_sleep_delay = 19'h00000;
    ctl1_sp1_wake_level = 16'sh0000; ctl1_sp2_wake_level = 16'sh0000; ctl1_wake_action = 2'h0;
    go(4); st(16'sh0000, 1'b0, 1'b0);
    go(1); rst <= 1'b0;
    go(1); st(16'sh0123, 1'b0, 1'b0);
    `CHK(ctl1_ff_scaled, 16'sh0111)
    foreach (ffr[k]) begin
      go(1); ctl1_feedforward_gain <= ffr[k].g; ctl1_ff_in <= ffr[k].f;
      go(1); @(negedge sys_clk);
      `CHK(ctl1_ff_scaled, ffr[k].e)
      `CHK(ctl2_ff_scaled, ffr[k].e)
    end
    done("gain");
    go(1); ctl1_dead_band_width <= 16'h000a; ctl1_dead_band_delay <= 16'h0005;
    ctl1_error <= 16'sh0003; ctl1_pid_raw <= 16'sh0064;
    go(1); st(16'sh0064, 1'b1, 1'b0);
    go(1); ctl1_pid_raw <= 16'sh00c8;
    go(3); st(16'sh0064, 1'b1, 1'b0);
    go(1); ctl1_error <= 16'sh0032;
    go(10); ctl1_error <= -16'sh0003;
    go(2); ctl1_error <= 16'sh0032;
    go(14); st(16'sh0064, 1'b1, 1'b0);
    for (i = 0; i < 30 && ctl1_frozen !== 1'b0; i++) @(negedge sys_clk);
    st(16'sh00c8, 1'b0, 1'b0);
    go(1); ctl1_dead_band_width <= 16'h0000; ctl1_pid_raw <= 16'sh0123; tgt <= 16'sh0190;
    ctl1_sp1_sleep_level <= 16'sh01f4; ctl1_sp1_sleep_delay <= 19'h00005;
    ctl1_sp1_sleep_enable <= 1'b1;
    go(16); st(16'sh0123, 1'b0, 1'b0);
    go(1); tgt <= 16'sh0258;
    go(1); tgt <= 16'sh0190;
    go(17); st(16'sh0123, 1'b0, 1'b0);
    for (i = 0; i < 40 && ctl1_asleep !== 1'b1; i++) @(negedge sys_clk);
    st(16'sh0000, 1'b0, 1'b1);
    go(1); ctl1_sp1_sleep_enable <= 1'b0;
    go(1); st(16'sh0123, 1'b0, 1'b0);
    done("dead band and sleep delay");
    foreach (sr[k]) begin
      go(1); ctl1_sp1_sleep_enable <= 1'b0; ctl1_sp1_sleep_ref_select <= sr[k].sel;
      ctl1_sp1_sleep_level <= sr[k].lvl; ctl1_sp1_sleep_delay <= 19'h00000;
      go(1); ctl1_sp1_sleep_enable <= 1'b1;
      go(10); st(sr[k].s ? 16'sh0000 : 16'sh0123, 1'b0, sr[k].s);
    end
    done("sleep reference");
    foreach (wr[k]) begin
      go(1); ctl1_sp1_sleep_enable <= 1'b0; ctl1_sp1_sleep_ref_select <= 2'h0;
      ctl1_sp1_sleep_level <= 16'sh01f4; tgt <= 16'sh0190; ctl1_wake_action <= wr[k].a;
      ctl1_sp1_wake_level <= 16'sh01f4; ctl1_setpoint <= wr[k].sp; ctl1_feedback <= wr[k].h;
      go(1); ctl1_sp1_sleep_enable <= 1'b1;
      go(10); st(16'sh0000, 1'b0, 1'b1);
      go(1); tgt <= 16'sh0258; ctl1_feedback <= wr[k].t;
      go(2); st(wr[k].s ? 16'sh0000 : 16'sh0123, 1'b0, wr[k].s);
    end
    done("wake action");
    go(1); ctl1_sp1_sleep_enable <= 1'b0; tgt <= 16'sh0190; ctl1_wake_action <= 2'h0;
    ctl1_feedback <= 16'sh03e8; ctl1_sp2_active <= 1'b1; ctl1_sp2_sleep_level <= 16'sh012c;
    go(1); ctl1_sp1_sleep_enable <= 1'b1; ctl1_sp2_sleep_enable <= 1'b1;
    go(10); st(16'sh0123, 1'b0, 1'b0);
    go(1); ctl1_sp2_active <= 1'b0;
    go(10); st(16'sh0000, 1'b0, 1'b1);
    go(1); rst <= 1'b1;
    go(2); st(16'sh0000, 1'b0, 1'b0);
    go(1); ctl1_sp1_sleep_enable <= 1'b0; ctl1_sp2_sleep_enable <= 1'b0;
    go(2); rst <= 1'b0;
    go(2); st(16'sh0123, 1'b0, 1'b0);
    done("set point two and reset");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
